// >>> hdl/stsc_cfg.svh
`ifndef STSC_CFG_SVH
`define STSC_CFG_SVH

// Register indices, byte address is four times the index
`define STSC_IDX_NOISE   8'h38
`define STSC_IDX_MASK    8'h40
`define STSC_IDX_TIMING  8'h41
`define STSC_IDX_GAIN    8'h42
`define STSC_IDX_THR     8'h43
`define STSC_IDX_CTRL    8'h44
`define STSC_IDX_STAT    8'h45
`define STSC_IDX_LAST    8'h46

// Reset values
`define STSC_RST_NOISE   8'h01
`define STSC_RST_MASK    8'h00
`define STSC_RST_TIMING  8'h39
`define STSC_RST_GAIN    8'h02
`define STSC_RST_THR     8'h40
`define STSC_RST_CTRL    8'h00

// Field positions
`define STSC_TM_ACC_BIT  7
`define STSC_TM_CNT_LSB  4
`define STSC_TM_SPT_LSB  2
`define STSC_TM_CYC_LSB  0
`define STSC_CTRL_EN_BIT 0
`define STSC_CTRL_NRO_BIT 1
`define STSC_ST_STR_BIT  16
`define STSC_ST_BUSY_BIT 17

// Timing, figures in their own units
`define STSC_CLK_PERIOD_NS 5
`define STSC_SAMP_UNIT_US  320
`define STSC_CYC_UNIT_MS   35

// Avalon responses
`define STSC_RESP_OK     2'h0
`define STSC_RESP_SLVERR 2'h2

`endif

// >>> hdl/stsc_pkg.sv
package stsc_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SAMPLE,
    ST_COMBINE,
    ST_REST
  } stsc_state_e;

  typedef logic [7:0]  stsc_byte_t;
  typedef logic [31:0] stsc_word_t;
endpackage : stsc_pkg

// >>> hdl/stsc_timer.sv
`timescale 1ns/1ps
module stsc_timer
  import stsc_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  // Status
  output logic                  done_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } stsc_tmr_s;

  stsc_tmr_s r;
  stsc_tmr_s n;

  // Down count, loaded value covers value_i cycles
  always_comb begin
    n = r;
    if (load_i) begin
      n.cnt = value_i - CNT_W'(1);
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done_o = (r.cnt == '0);
endmodule : stsc_timer

// >>> hdl/stsc_accum.sv
`timescale 1ns/1ps
module stsc_accum
  import stsc_pkg::*;
#(
  parameter int SAMP_W = 16,
  parameter int ACC_W  = 23,
  parameter int OUT_W  = 7
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Sample stream
  input  wire logic              clr_i,
  input  wire logic              add_i,
  input  wire logic [SAMP_W-1:0] sample_i,
  // Shaping
  input  wire logic [2:0]        avg_code_i,
  input  wire logic              sum_mode_i,
  input  wire logic [2:0]        gain_i,
  // Result
  output logic      [OUT_W-1:0]  delta_o
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } stsc_acc_s;

  localparam logic [ACC_W-1:0] SAT_MAX = ACC_W'((1 << OUT_W) - 1);

  stsc_acc_s        r;
  stsc_acc_s        n;
  logic [ACC_W-1:0] formed;
  logic [ACC_W-1:0] scaled;

  // Sum of one input's samples, wide enough for 128 full samples
  always_comb begin
    n = r;
    if (clr_i) begin
      n.acc = '0;
    end else if (add_i) begin
      n.acc = r.acc + ACC_W'(sample_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Shape the sum into a delta count
  always_comb begin
    formed = sum_mode_i ? r.acc : (r.acc >> avg_code_i);
    scaled = formed >> gain_i;
    delta_o = (scaled > SAT_MAX) ? SAT_MAX[OUT_W-1:0] : scaled[OUT_W-1:0];
  end
endmodule : stsc_accum

// >>> hdl/stsc_top.sv
`timescale 1ns/1ps
`include "stsc_cfg.svh"
module stsc_top
  import stsc_pkg::*;
#(
  parameter int unsigned SAMP_UNIT_CYC =
    `STSC_SAMP_UNIT_US * 1000 / `STSC_CLK_PERIOD_NS,
  parameter int unsigned CYC_UNIT_CYC  =
    `STSC_CYC_UNIT_MS * 1000000 / `STSC_CLK_PERIOD_NS,
  parameter int          N_IN          = 8,
  parameter int          SAMP_W        = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Avalon-MM slave
  input  wire logic [9:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic      [1:0]        avs_response_o,
  output logic                   avs_waitrequest_o,
  // Analog front end
  output logic                   afe_req_o,
  output logic      [2:0]        afe_sel_o,
  input  wire logic [SAMP_W-1:0] afe_delta_i,
  // Measurement results
  output logic      [N_IN-1:0]   touch_o,
  output logic                   recal_valid_o,
  output logic                   recal_use_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    stsc_state_e st;
    stsc_byte_t  noise_cfg;
    stsc_byte_t  mask;
    stsc_byte_t  timing;
    stsc_byte_t  gain;
    stsc_byte_t  thr;
    stsc_byte_t  ctrl;
    stsc_byte_t  snap_mask;
    stsc_byte_t  snap_timing;
    logic [2:0]  snap_gain;
    logic [2:0]  ch;
    logic [7:0]  cnt;
    logic [7:0]  touch;
    logic [7:0]  noise_flags;
    logic        stretch;
    logic [6:0]  last_delta;
    logic [2:0]  last_ch;
    logic        afe_req;
    logic        recal_valid;
    logic        recal_use;
    logic        wait_r;
    stsc_word_t  rdata;
    logic [1:0]  resp;
  } stsc_top_s;

  stsc_top_s   r;
  stsc_top_s   n;
  logic        samp_load;
  logic        cyc_load;
  logic        acc_clr;
  logic        acc_add;
  logic [31:0] samp_val;
  logic [31:0] cyc_val;
  logic        samp_done;
  logic        cyc_done;
  logic [6:0]  delta;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // First enabled input at or above a start index, found flag on top
  function automatic logic [3:0] stsc_next(input logic [7:0] m,
                                           input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (!res[3] && (4'(i) >= from) && m[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : stsc_next

  function automatic logic [6:0] stsc_noise_lvl(input logic [6:0] t,
                                                input logic [1:0] sel);
    logic [6:0] lvl;
    lvl = 7'h00;
    unique case (sel)
      2'b00: lvl = t >> 2;
      2'b01: lvl = (t >> 2) + (t >> 3);
      2'b10: lvl = t >> 1;
      2'b11: lvl = (t >> 1) + (t >> 3);
    endcase
    return lvl;
  endfunction : stsc_noise_lvl

  function automatic logic [31:0] stsc_samp_cyc(input logic [1:0] code);
    return 32'(SAMP_UNIT_CYC) << code;
  endfunction : stsc_samp_cyc

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  stsc_timer #(.CNT_W(32)) u_samp_tmr (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (samp_load),
    .value_i (samp_val),
    .done_o  (samp_done)
  );

  stsc_timer #(.CNT_W(32)) u_cyc_tmr (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (cyc_load),
    .value_i (cyc_val),
    .done_o  (cyc_done)
  );

  stsc_accum #(.SAMP_W(SAMP_W), .ACC_W(SAMP_W + 7), .OUT_W(7)) u_acc (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .clr_i      (acc_clr),
    .add_i      (acc_add),
    .sample_i   (afe_delta_i),
    .avg_code_i (r.snap_timing[`STSC_TM_CNT_LSB +: 3]),
    .sum_mode_i (r.snap_timing[`STSC_TM_ACC_BIT]),
    .gain_i     (r.snap_gain),
    .delta_o    (delta)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [3:0] nx;
    logic [7:0] idx;
    logic       hit;
    logic       is_noise;
    logic [1:0] spt;
    nx        = 4'h0;
    idx       = avs_address_i[9:2];
    hit       = 1'b1;
    is_noise  = 1'b0;
    spt       = r.snap_timing[`STSC_TM_SPT_LSB +: 2];
    n         = r;
    samp_load = 1'b0;
    cyc_load  = 1'b0;
    acc_clr   = 1'b0;
    acc_add   = 1'b0;
    n.recal_valid = 1'b0;

    // Bus: one wait cycle, then a one-cycle acknowledge
    n.wait_r = !((avs_read_i || avs_write_i) && r.wait_r);
    unique case (idx)
      `STSC_IDX_NOISE:  n.rdata = {24'h00_0000, r.noise_cfg};
      `STSC_IDX_MASK:   n.rdata = {24'h00_0000, r.mask};
      `STSC_IDX_TIMING: n.rdata = {24'h00_0000, r.timing};
      `STSC_IDX_GAIN:   n.rdata = {24'h00_0000, r.gain};
      `STSC_IDX_THR:    n.rdata = {24'h00_0000, r.thr};
      `STSC_IDX_CTRL:   n.rdata = {24'h00_0000, r.ctrl};
      `STSC_IDX_STAT:   n.rdata = {14'h0000, r.st != ST_OFF, r.stretch,
                                   r.noise_flags, r.touch};
      `STSC_IDX_LAST:   n.rdata = {21'h00_0000, r.last_ch, 1'b0,
                                   r.last_delta};
      default: begin
        n.rdata = 32'h0000_0000;
        hit     = 1'b0;
      end
    endcase
    n.resp = hit ? `STSC_RESP_OK : `STSC_RESP_SLVERR;

    // Writes land on the acknowledge edge; reserved bits stay zero
    if (avs_write_i && !r.wait_r && avs_byteenable_i[0]) begin
      unique case (idx)
        `STSC_IDX_NOISE:  n.noise_cfg = {6'h00, avs_writedata_i[1:0]};
        `STSC_IDX_MASK:   n.mask      = avs_writedata_i[7:0];
        `STSC_IDX_TIMING: n.timing    = avs_writedata_i[7:0];
        `STSC_IDX_GAIN:   n.gain      = {5'h00, avs_writedata_i[2:0]};
        `STSC_IDX_THR:    n.thr       = {1'b0, avs_writedata_i[6:0]};
        `STSC_IDX_CTRL:   n.ctrl      = {6'h00, avs_writedata_i[1:0]};
        default: ;
      endcase
    end
    // Stretch flag clears on write-one; a new stretch below wins
    if (avs_write_i && !r.wait_r && idx == `STSC_IDX_STAT &&
        avs_writedata_i[`STSC_ST_STR_BIT]) begin
      n.stretch = 1'b0;
    end

    // Scan sequencer
    unique case (r.st)
      ST_OFF, ST_REST: begin
        n.afe_req = 1'b0;
        if (r.ctrl[`STSC_CTRL_EN_BIT] && (r.st == ST_OFF || cyc_done)) begin
          // Mask, timing and gain are frozen for the whole cycle
          n.snap_mask   = r.mask;
          n.snap_timing = r.timing;
          n.snap_gain   = r.gain[2:0];
          cyc_load      = 1'b1;
          nx            = stsc_next(r.mask, 4'h0);
          if (nx[3]) begin
            n.st      = ST_SAMPLE;
            n.ch      = nx[2:0];
            n.cnt     = 8'h00;
            n.afe_req = 1'b1;
            samp_load = 1'b1;
            acc_clr   = 1'b1;
          end else begin
            n.st = ST_REST;
          end
        end else if (r.st == ST_REST && cyc_done) begin
          n.st = ST_OFF;
        end
      end
      ST_SAMPLE: begin
        if (samp_done) begin
          acc_add = 1'b1;
          if (r.cnt == 8'((9'h001 << r.snap_timing[`STSC_TM_CNT_LSB +: 3])
                          - 9'h001)) begin
            n.st      = ST_COMBINE;
            n.afe_req = 1'b0;
          end else begin
            n.cnt     = r.cnt + 8'h01;
            samp_load = 1'b1;
          end
        end
      end
      ST_COMBINE: begin
        n.touch[r.ch] = delta > r.thr[6:0];
        is_noise = !r.ctrl[`STSC_CTRL_NRO_BIT] &&
                   (delta > stsc_noise_lvl(r.thr[6:0], r.noise_cfg[1:0])) &&
                   (delta <= r.thr[6:0]);
        n.noise_flags[r.ch] = is_noise;
        n.last_delta  = delta;
        n.last_ch     = r.ch;
        n.recal_valid = 1'b1;
        n.recal_use   = !is_noise;
        nx = stsc_next(r.snap_mask, {1'b0, r.ch} + 4'h1);
        if (nx[3]) begin
          n.st      = ST_SAMPLE;
          n.ch      = nx[2:0];
          n.cnt     = 8'h00;
          n.afe_req = 1'b1;
          samp_load = 1'b1;
          acc_clr   = 1'b1;
        end else begin
          n.st = ST_REST;
          if (cyc_done) begin
            n.stretch = 1'b1;
          end
        end
      end
    endcase

    // Timer values follow the settings in force for the new sample
    if (cyc_load) begin
      spt = r.timing[`STSC_TM_SPT_LSB +: 2];
    end
    samp_val = stsc_samp_cyc(spt);
    cyc_val  = 32'(CYC_UNIT_CYC) *
               (32'(r.timing[`STSC_TM_CYC_LSB +: 2]) + 32'h0000_0001);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r             <= '0;
      r.st          <= ST_OFF;
      r.noise_cfg   <= `STSC_RST_NOISE;
      r.mask        <= `STSC_RST_MASK;
      r.timing      <= `STSC_RST_TIMING;
      r.gain        <= `STSC_RST_GAIN;
      r.thr         <= `STSC_RST_THR;
      r.ctrl        <= `STSC_RST_CTRL;
      r.snap_timing <= `STSC_RST_TIMING;
      r.wait_r      <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops
  assign avs_readdata_o    = r.rdata;
  assign avs_response_o    = r.resp;
  assign avs_waitrequest_o = r.wait_r;
  assign afe_req_o         = r.afe_req;
  assign afe_sel_o         = r.ch;
  assign touch_o           = r.touch;
  assign recal_valid_o     = r.recal_valid;
  assign recal_use_o       = r.recal_use;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_REQ_IN_SAMPLE: assert property (
    afe_req_o |-> r.st == ST_SAMPLE)
    else $error("front end request outside sampling");

  AST_MASKED_ONLY: assert property (
    afe_req_o |-> r.snap_mask[afe_sel_o])
    else $error("masked input sampled");

  AST_EMPTY_IDLE: assert property (
    (r.st != ST_OFF && r.snap_mask == 8'h00) |-> !afe_req_o)
    else $error("sampling with empty mask");

  AST_NRO_PASS: assert property (
    recal_valid_o && $past(r.ctrl[`STSC_CTRL_NRO_BIT]) |-> recal_use_o)
    else $error("noise rejected while disabled");

  AST_NOISE_BAND: assert property (
    recal_valid_o && !recal_use_o |->
      r.last_delta <= $past(r.thr[6:0]) &&
      r.last_delta > stsc_noise_lvl($past(r.thr[6:0]),
                                    $past(r.noise_cfg[1:0])))
    else $error("noise outside band");

  AST_TOUCH: assert property (
    recal_valid_o |->
      touch_o[r.last_ch] == (r.last_delta > $past(r.thr[6:0])))
    else $error("touch decision wrong");

  AST_BUS_ACK: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus acknowledge not one cycle");

  AST_COUNT_DONE: assert property (
    r.st == ST_SAMPLE ##1 r.st == ST_COMBINE |->
      $past(r.cnt) ==
      8'((9'h001 << r.snap_timing[`STSC_TM_CNT_LSB +: 3]) - 9'h001))
    else $error("wrong number of samples");

  // An empty mask stays in rest but must reload the period timer
  AST_REST_EXIT: assert property (
    r.st == ST_REST && cyc_done |=> r.st != ST_REST || !cyc_done)
    else $error("rest outlived the period");

  AST_STRETCH: assert property (
    r.st == ST_COMBINE && cyc_done && n.st == ST_REST |=> r.stretch)
    else $error("stretch not flagged");

  COV_NOISE:   cover property (recal_valid_o && !recal_use_o);
  COV_TOUCH:   cover property (recal_valid_o && |touch_o);
  COV_STRETCH: cover property ($rose(r.stretch));
  COV_EMPTY:   cover property (r.st == ST_REST && r.snap_mask == 8'h00);
endmodule : stsc_top

// >>> tb/stsc_afe_model.sv
`timescale 1ns/1ps
module stsc_afe_model
  import stsc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Scan request from the block
  input  wire logic         afe_req_i,
  input  wire logic [2:0]   afe_sel_i,
  // Raw level of each input, set by the bench
  input  wire logic [127:0] level_i,
  // Raw delta back to the block
  output logic      [15:0]  afe_delta_o
);
  logic [15:0] last_r;

  ////////////////////////////////////////////////////////////////////////////
  // Last value seen, so an idle line never repeats it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_r <= 16'h0000;
    end else begin
      last_r <= afe_delta_o;
    end
  end

  // selected input held
  // Idle line toggles every cycle so a stale read cannot pass by luck
  always_comb begin
    if (afe_req_i) begin
      afe_delta_o = level_i[{afe_sel_i, 4'h0} +: 16];
    end else begin
      afe_delta_o = ~last_r;
    end
  end
endmodule : stsc_afe_model

// >>> tb/test_standby_touch_scan_config.sv
`timescale 1ns/1ps
`include "stsc_cfg.svh"
module test_standby_touch_scan_config
  import stsc_pkg::*;
;
  typedef struct packed {
    stsc_byte_t idx;
    stsc_byte_t wd;
    stsc_word_t exp;
    logic [1:0] resp;
  } stsc_tb_row_s;

  logic         clk_i, rst_n_i, avs_read, avs_write, avs_wait;
  logic [9:0]   avs_address;
  logic [31:0]  avs_wdata, avs_rdata;
  logic [3:0]   avs_be;
  logic [1:0]   avs_resp, rsp;
  logic         afe_req, recal_valid, recal_use, meas_use, req_d = 1'b0;
  logic [2:0]   afe_sel, meas_sel, run_sel;
  logic [15:0]  afe_delta;
  logic [7:0]   touch;
  logic [127:0] level;
  stsc_word_t   rd;
  int n_fail = 0, comparisons = 0, cyc = 0, hi_cnt = 0, last_hi = 0;
  int rise_cyc = 0, last_per = 0, n_meas = 0, i, d, keep;
  stsc_tb_row_s rows [6] = '{
    '{`STSC_IDX_NOISE,  8'hFF, 32'h0000_0003, 2'h0},
    '{`STSC_IDX_MASK,   8'hA5, 32'h0000_00A5, 2'h0},
    '{`STSC_IDX_TIMING, 8'h5A, 32'h0000_005A, 2'h0},
    '{`STSC_IDX_GAIN,   8'hFF, 32'h0000_0007, 2'h0},
    '{`STSC_IDX_THR,    8'hFF, 32'h0000_007F, 2'h0},
    '{8'h50,            8'h5A, 32'h0000_0000, 2'h2}};

  stsc_top #(.SAMP_UNIT_CYC(4), .CYC_UNIT_CYC(200)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_wdata), .avs_byteenable_i(avs_be),
    .avs_readdata_o(avs_rdata), .avs_response_o(avs_resp),
    .avs_waitrequest_o(avs_wait), .afe_req_o(afe_req), .afe_sel_o(afe_sel),
    .afe_delta_i(afe_delta), .touch_o(touch), .recal_valid_o(recal_valid),
    .recal_use_o(recal_use));

  stsc_afe_model afe_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .afe_req_i(afe_req),
    .afe_sel_i(afe_sel), .level_i(level), .afe_delta_o(afe_delta));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Measurement bookkeeping on the quiet edge
  always @(negedge clk_i) begin
    cyc++;
    if (afe_req && !req_d) begin
      last_per = cyc - rise_cyc;
      rise_cyc = cyc;
    end
    req_d = afe_req;
    if (recal_valid) begin
      last_hi = hi_cnt;
      hi_cnt = afe_req ? 1 : 0;
      meas_sel = run_sel;
      meas_use = recal_use;
      n_meas++;
    end else if (afe_req) begin
      hi_cnt++;
    end
    if (afe_req) run_sel = afe_sel;
  end

  // Watchdog, well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input stsc_word_t got, input stsc_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask : chk_bit

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic wr, input stsc_byte_t idx,
                     input stsc_byte_t wd);
    avs_address <= {idx, 2'b00};
    avs_write   <= wr;
    avs_read    <= !wr;
    avs_wdata   <= {24'h00_0000, wd};
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (avs_wait !== 1'b0);
    rd = avs_rdata;
    rsp = avs_resp;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input stsc_byte_t idx, input stsc_byte_t wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input stsc_byte_t idx, input stsc_word_t exp);
    bus(1'b0, idx, 8'h00);
    chk_word(rd, exp);
  endtask : rdc

  // Bounded wait for n more finished input measurements
  task automatic wait_meas(input int n);
    int k;
    int start;
    start = n_meas;
    for (k = 0; k < 5000; k++) begin
      if (n_meas >= start + n) break;
      @(posedge clk_i);
    end
    if (n_meas < start + n) begin
      n_fail++;
      $display("unexpected at %0t: no measurement", $time);
    end
  endtask : wait_meas

  task automatic wait_sel(input logic [2:0] s);
    int k;
    for (k = 0; k < 8; k++) begin
      wait_meas(1);
      if (meas_sel === s) break;
    end
    if (meas_sel !== s) begin
      n_fail++;
      $display("unexpected at %0t: input never measured", $time);
    end
  endtask : wait_sel

  task close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    avs_address = 10'h000;
    {avs_read, avs_write} = 2'h0;
    avs_wdata = 32'h0000_0000;
    avs_be = 4'h1;
    level = '0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_bit(avs_wait, 1'b1);
    chk_bit(afe_req, 1'b0);
    rdc(`STSC_IDX_NOISE, 32'h0000_0001);
    rdc(`STSC_IDX_MASK, 32'h0000_0000);
    rdc(`STSC_IDX_TIMING, 32'h0000_0039);
    rdc(`STSC_IDX_GAIN, 32'h0000_0002);
    rdc(`STSC_IDX_THR, 32'h0000_0040);
    // Register rows: write, read back, response code
    for (i = 0; i < 6; i++) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].exp);
      chk_word({30'h0, rsp}, {30'h0, rows[i].resp});
    end
    // Byte lane 0 off stores nothing
    avs_be <= 4'h0;
    wr(`STSC_IDX_MASK, 8'h3C);
    avs_be <= 4'h1;
    rdc(`STSC_IDX_MASK, 32'h0000_00A5);
    // Inputs 1 and 3, two samples each, raw gain
    level[15:0] <= 16'h0020;
    level[47:32] <= 16'h0009;
    wr(`STSC_IDX_THR, 8'h10);
    wr(`STSC_IDX_GAIN, 8'h00);
    wr(`STSC_IDX_TIMING, 8'h10);
    wr(`STSC_IDX_MASK, 8'h05);
    wr(`STSC_IDX_NOISE, 8'h00);
    wr(`STSC_IDX_CTRL, 8'h01);
    wait_sel(3'h0);
    chk_word(32'(last_hi), 32'h0000_0008);
    wait_meas(1);
    chk_word({29'h0, meas_sel}, 32'h0000_0002);
    chk_bit(meas_use, 1'b0);
    chk_word({24'h0, touch}, 32'h0000_0001);
    rdc(8'h46, 32'h0000_0209);
    // Noise level per ratio code: 9 against 4, 6, 8, 10
    for (i = 0; i < 4; i++) begin
      wr(`STSC_IDX_NOISE, 8'(i));
      wait_sel(3'h0);
      wait_sel(3'h2);
      chk_bit(meas_use, i == 3);
    end
    wr(`STSC_IDX_CTRL, 8'h03);
    wait_sel(3'h0);
    wait_sel(3'h2);
    chk_bit(meas_use, 1'b1);
    // Input 8 alone: sample time, cycle time and gain per code
    level[127:112] <= 16'h0100;
    wr(`STSC_IDX_MASK, 8'h80);
    for (i = 0; i < 4; i++) begin
      wr(`STSC_IDX_TIMING, {4'h0, i[1:0], i[1:0]});
      wr(`STSC_IDX_GAIN, 8'(i));
      wait_meas(3);
      d = (256 >> i) > 127 ? 127 : (256 >> i);
      chk_word(32'(last_hi), 32'(4 << i));
      chk_word(32'(last_per), 32'(200 * (i + 1)));
      rdc(8'h46, 32'h0000_0700 + 32'(d));
    end
    // Summed 128 samples overflow, clipped; scan outruns the period
    wr(`STSC_IDX_TIMING, 8'hF0);
    wr(`STSC_IDX_GAIN, 8'h07);
    wait_meas(3);
    chk_word(32'(last_hi), 32'h0000_0200);
    rdc(8'h46, 32'h0000_077F);
    chk_bit(last_per > 200, 1'b1);
    bus(1'b0, `STSC_IDX_STAT, 8'h00);
    chk_bit(rd[16], 1'b1);
    // Empty mask: no sampling while enabled
    wr(`STSC_IDX_MASK, 8'h00);
    repeat (1200) @(posedge clk_i);
    keep = rise_cyc;
    repeat (1000) @(posedge clk_i);
    chk_word(32'(rise_cyc), 32'(keep));
    chk_bit(afe_req, 1'b0);
    // Mid-run reset: settings, touches and sticky flags back to reset
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_bit(avs_wait, 1'b1);
    chk_word({24'h0, touch}, 32'h0000_0000);
    rdc(`STSC_IDX_MASK, 32'h0000_0000);
    rdc(`STSC_IDX_TIMING, 32'h0000_0039);
    rdc(`STSC_IDX_STAT, 32'h0000_0000);
    wr(`STSC_IDX_CTRL, 8'h00);
    close_out;
  end
endmodule : test_standby_touch_scan_config
